// ===== logic/move_decoder_pkg.sv
// Contract
// - fetch and execute each instruction in one clock, no pipeline
// - decode fixed 16-bit words; any register may pair with accumulator
// - bit 15 picks how the source field is read
// - bits 7:0 give the source: immediate byte or register selector
// - register source: low nibble module, high nibble index
// - bits 14:8 always name a destination register
// - destination: low four bits module, high three bits subindex
// - stored prefix joins destination field to reach upper registers
// - prefix write costs exactly one extra cycle before the transfer
// - reads and writes of certain locations cause side effects
// - every operation is a move between register locations
// - sixteen-entry hardware stack for returns and storage
// - three data pointers that step up or down after access; the code steps one only after a read through it, not after a write
// - utility ROM 4kB, program flash 32kWords, data SRAM 1kWord
// - after reset program and data spaces are separate
// - a mode maps data memory into program space; the code drives prog_addr_o with next_pc in every mode
// - a mode maps program memory into data space
// - unified mode places ROM, program and data in one map
// - program memory lockable behind a sixteen-word key
// - reset stack index to top; push increments then writes
// - pop reads current entry then decrements
package move_decoder_pkg;
    localparam int          INSTR_W      = 16;
    localparam int          FMT_BIT      = 15;
    localparam int          SRC_LSB      = 0;
    localparam int          DST_LSB      = 8;
    localparam int          STACK_DEPTH  = 16;
    localparam int          KEY_WORDS    = 16;
    localparam int          ROM_BYTES    = 4096;
    localparam int          FLASH_WORDS  = 32768;
    localparam int          SRAM_WORDS   = 1024;
    localparam logic [3:0]  STACK_TOP_RST = 4'h f;
    localparam logic [15:0] ROM_BASE     = 16'h8000;
    localparam logic [15:0] DATA_IN_PROG = 16'hA000;
    localparam logic [15:0] PROG_IN_DATA = 16'h8000;
    localparam logic [15:0] PC_RST       = 16'h8000;
    localparam logic [15:0] KEY_BASE     = 16'h0010;
    // module specifiers
    localparam logic [3:0]  MOD_AP   = 4'h8;
    localparam logic [3:0]  MOD_ACC  = 4'h9;
    localparam logic [3:0]  MOD_PFX  = 4'hB;
    localparam logic [3:0]  MOD_PC   = 4'hC;
    localparam logic [3:0]  MOD_STK  = 4'hD;
    localparam logic [3:0]  MOD_DPC  = 4'hE;
    localparam logic [3:0]  MOD_DP   = 4'hF;
    // index values inside modules
    localparam logic [3:0]  IDX_SP   = 4'h1;
    localparam logic [3:0]  IDX_DP0  = 4'h3;
    localparam logic [3:0]  IDX_DP1  = 4'h7;
    localparam logic [3:0]  IDX_BP   = 4'h7;
    localparam logic [3:0]  IDX_STEP = 4'h4;
    localparam logic [3:0]  IDX_PUSH = 4'h0;
    localparam logic [3:0]  IDX_MCFG = 4'h8;
    localparam logic [3:0]  IDX_KEY  = 4'h9;
    // accumulator-module ALU side-effect indices (module MOD_AP)
    localparam logic [3:0]  IDX_ADD  = 4'h2;
    localparam logic [3:0]  IDX_AND  = 4'h3;
    localparam logic [3:0]  IDX_OR   = 4'h5;
    localparam logic [3:0]  IDX_XOR  = 4'h7;
    localparam logic [1:0]  MAP_HARVARD = 2'h0;
    localparam logic [1:0]  MAP_D2P     = 2'h1;
    localparam logic [1:0]  MAP_P2D     = 2'h2;
    localparam logic [1:0]  MAP_UNIFIED = 2'h3;

    typedef struct packed {
        logic        fmt;
        logic [6:0]  dst;
        logic [7:0]  src;
    } instr_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [15:0] wdata;
    } mem_req_t;
endpackage

// ===== logic/move_instruction_decoder.sv
`timescale 1ns/1ps
module move_instruction_decoder
    import move_decoder_pkg::*;
#(
    parameter int NUM_DP = 3
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] prog_rdata_i,
    input  wire logic [15:0] data_rdata_i,
    input  wire logic [15:0] periph_rdata_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [15:0] bus_wdata_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_rd_i,
    output logic      [15:0] prog_addr_o,
    output mem_req_t         data_req_o,
    output logic      [7:0]  periph_sel_o,
    output logic             periph_wr_o,
    output logic      [15:0] periph_wdata_o,
    output logic      [15:0] acc_o,
    output logic      [3:0]  stack_top_index_o,
    output logic             key_locked_o,
    output logic      [1:0]  map_mode_o,
    output logic      [15:0] bus_rdata_o
);
    typedef enum logic [0:0] {RUN, PFX_WAIT} phase_t;

    phase_t      phase, next_phase;
    logic [15:0] pc;
    logic [15:0] acc;
    logic [7:0]  destination_prefix_reg;
    logic [3:0]  stack_top_index;
    logic [15:0] stack_mem [STACK_DEPTH];
    logic [15:0] dp [NUM_DP];
    logic [NUM_DP-1:0] dp_dec;
    logic [1:0]  dp_sel;
    logic [1:0]  map_mode;
    logic        key_locked;
    logic [3:0]  key_cnt;
    logic        key_ok;

    function automatic logic [15:0] alu(input logic [3:0] op,
                                        input logic [15:0] a,
                                        input logic [15:0] b);
        case (op)
            IDX_ADD: alu = a + b;
            IDX_AND: alu = a & b;
            IDX_OR:  alu = a | b;
            IDX_XOR: alu = a ^ b;
            default: alu = b;
        endcase
    endfunction

    // decode happens on the live fetch word, so no pipeline stage
    instr_t      ins;
    assign ins = instr_t'(prog_rdata_i);
    wire         src_is_reg = ins.fmt;
    wire  [3:0]  src_mod    = ins.src[3:0];
    wire  [3:0]  src_idx    = ins.src[7:4];
    wire  [3:0]  dst_mod    = ins.dst[3:0];
    wire  [2:0]  dst_sub    = ins.dst[6:4];
    // prefix supplies upper destination index bits
    wire  [4:0]  dst_full   = {destination_prefix_reg[1:0], dst_sub};
    wire  [3:0]  dst_idx    = dst_full[3:0];
    wire         dst_hi     = dst_full[4];
    wire  [1:0]  sdp        = (src_idx == IDX_DP0) ? 2'd0 :
                              (src_idx == IDX_DP1) ? 2'd1 : 2'd2;
    wire  [1:0]  ddp        = (dst_idx == IDX_DP0) ? 2'd0 :
                              (dst_idx == IDX_DP1) ? 2'd1 : 2'd2;
    wire         src_dp     = src_is_reg && src_mod == MOD_DP;
    wire         dst_dp     = !dst_hi && dst_mod == MOD_DP;
    wire         src_pop    = src_is_reg && src_mod == MOD_STK
                              && src_idx == IDX_PUSH;
    wire         dst_push   = !dst_hi && dst_mod == MOD_STK
                              && dst_idx == IDX_PUSH;
    wire         is_pfx     = dst_mod == MOD_PFX;

    // source value mux, immediate or register
    logic [15:0] src_val;
    always_comb begin
        src_val = periph_rdata_i;
        if (!src_is_reg) begin
            src_val = {8'h00, ins.src};
        end else begin
            case (src_mod)
                MOD_ACC: src_val = acc;
                MOD_PFX: src_val = {8'h00, destination_prefix_reg};
                MOD_PC:  src_val = pc;
                MOD_STK: src_val = src_pop ? stack_mem[stack_top_index]
                                  : {12'h000, stack_top_index};
                MOD_DP:  src_val = data_rdata_i;
                MOD_DPC: src_val = {14'h0000, dp_sel};
                default: src_val = periph_rdata_i;
            endcase
        end
    end

    // side effects come from the destination location
    wire         wr_acc  = !dst_hi && dst_mod == MOD_ACC;
    wire         wr_alu  = !dst_hi && dst_mod == MOD_AP;
    wire         wr_jump = !dst_hi && dst_mod == MOD_PC;
    wire         wr_step = !dst_hi && dst_mod == MOD_DPC
                           && dst_idx == IDX_STEP;
    wire         wr_mcfg = !dst_hi && dst_mod == MOD_DPC
                           && dst_idx == IDX_MCFG;
    wire         wr_key  = !dst_hi && dst_mod == MOD_DPC
                           && dst_idx == IDX_KEY;
    wire         in_run  = phase == RUN;
    wire  [15:0] alu_res = alu(dst_idx, acc, src_val);

    // address translation between spaces per map mode
    function automatic logic [15:0] data_addr(input logic [1:0]  m,
                                              input logic [15:0] a);
        case (m)
            MAP_P2D:     data_addr = a;
            MAP_UNIFIED: data_addr = a;
            default:     data_addr = {6'h00, a[9:0]};
        endcase
    endfunction

    wire  [15:0] dacc    = src_dp ? dp[sdp] : dp[ddp];
    wire  [15:0] daddr   = data_addr(map_mode, dacc);
    // a data read of the key area is refused while locked
    wire         key_hit = daddr[15:4] == KEY_BASE[15:4];
    wire         deny    = key_locked && key_hit;
    // prefixed transfer still executes; the prefix write is the extra cycle
    wire  [15:0] next_pc = wr_jump ? src_val : pc + 16'h0001;
    wire  [15:0] next_acc = wr_acc ? src_val : wr_alu ? alu_res : acc;
    wire  [3:0]  next_stack_top_index = dst_push ? stack_top_index + 4'h1
                                      : src_pop ? stack_top_index - 4'h1
                                      : stack_top_index;
    wire  [1:0]  next_map_mode = wr_mcfg ? src_val[1:0] : map_mode;
    always_comb begin
        next_phase = RUN;
        if (in_run && is_pfx) begin
            next_phase = PFX_WAIT;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pc                     <= PC_RST;
            phase                  <= RUN;
            acc                    <= 16'h0000;
            destination_prefix_reg <= 8'h00;
            stack_top_index        <= STACK_TOP_RST;
            map_mode               <= MAP_HARVARD;
            key_locked             <= 1'b1;
            key_cnt                <= 4'h0;
            key_ok                 <= 1'b0;
            dp_sel                 <= 2'd0;
            dp_dec                 <= '0;
            for (int i = 0; i < NUM_DP; i++) begin
                dp[i] <= 16'h0000;
            end
        end else begin
            phase <= next_phase;
            pc    <= next_pc;
            if (phase == PFX_WAIT || !is_pfx) begin
                destination_prefix_reg <= 8'h00;
            end
            if (is_pfx) begin
                destination_prefix_reg <= src_val[7:0];
            end
            acc             <= next_acc;
            stack_top_index <= next_stack_top_index;
            if (dst_push) begin
                stack_mem[next_stack_top_index] <= src_val;
            end
            if (wr_step) begin
                dp_sel <= src_val[1:0];
                dp_dec <= src_val[NUM_DP+1:2];
            end
            if (wr_mcfg) begin
                map_mode <= src_val[1:0];
            end
            if (wr_key) begin
                // compare against key word read back from data memory on data_rdata_i
                key_cnt <= key_cnt + 4'h1;
                if (key_cnt == 4'h0) begin
                    key_ok <= 1'b1;
                end
                if (src_val != data_rdata_i) begin
                    key_ok <= 1'b0;
                end
                if (key_cnt == 4'(KEY_WORDS - 1)) begin
                    key_locked <= !(key_ok && src_val == data_rdata_i);
                end
            end
            if (dst_dp) begin
                dp[ddp] <= src_val;
            end
            // source pointer steps after a read through it, no extra instruction
            if (src_dp || (dst_dp == 1'b0 && src_dp)) begin
                dp[sdp] <= dp_dec[sdp] ? dp[sdp] - 16'h0001
                                       : dp[sdp] + 16'h0001;
            end
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            prog_addr_o       <= PC_RST;
            data_req_o        <= '0;
            periph_sel_o      <= 8'h00;
            periph_wr_o       <= 1'b0;
            periph_wdata_o    <= 16'h0000;
            acc_o             <= 16'h0000;
            stack_top_index_o <= STACK_TOP_RST;
            key_locked_o      <= 1'b1;
            map_mode_o        <= MAP_HARVARD;
            bus_rdata_o       <= 16'h0000;
        end else begin
            prog_addr_o <= (map_mode == MAP_D2P && next_pc >= DATA_IN_PROG)
                           ? next_pc : next_pc;
            data_req_o.addr  <= daddr;
            data_req_o.rd    <= src_dp && !deny;
            data_req_o.wr    <= dst_dp;
            data_req_o.wdata <= src_val;
            periph_sel_o     <= {dst_idx, dst_mod};
            periph_wr_o      <= !is_pfx && !wr_acc && !wr_alu
                                && !wr_jump && dst_mod < MOD_AP;
            periph_wdata_o   <= src_val;
            acc_o            <= next_acc;
            stack_top_index_o <= next_stack_top_index;
            key_locked_o     <= key_locked;
            map_mode_o       <= next_map_mode;
            bus_rdata_o      <= bus_rd_i ? (bus_addr_i[0] ? acc : pc)
                                         : 16'h0000;
        end
    end
    wire unused_ok = &{1'b0, bus_wr_i, bus_wdata_i, ROM_BYTES[0],
                       FLASH_WORDS[0], SRAM_WORDS[0], PROG_IN_DATA[0],
                       ROM_BASE[0], SRC_LSB[0], DST_LSB[0], FMT_BIT[0],
                       INSTR_W[0], IDX_SP[0], IDX_BP[0], MOD_STK[0]};
endmodule

// ===== tb/move_instruction_decoder_sva.sv
`timescale 1ns/1ps
module move_instruction_decoder_chk
    import move_decoder_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic [15:0] prog_rdata_i,
    input wire logic [15:0] periph_rdata_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic        bus_rd_i,
    input wire logic [15:0] prog_addr_o,
    input wire mem_req_t    data_req_o,
    input wire logic [7:0]  periph_sel_o,
    input wire logic        periph_wr_o,
    input wire logic [15:0] acc_o,
    input wire logic [3:0]  stack_top_index_o,
    input wire logic        key_locked_o,
    input wire logic [1:0]  map_mode_o,
    input wire logic [15:0] bus_rdata_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    // one idle cycle after reset release so $past never sees reset values
    logic live_q;
    always_ff @(posedge sys_clk_i) begin
        live_q <= nrst_i;
    end
    default disable iff (!nrst_i || !live_q);
    wire logic       fmt  = prog_rdata_i[15];
    wire logic [6:0] dst  = prog_rdata_i[14:8];
    wire logic [3:0] dmod = prog_rdata_i[11:8];
    // prefixed moves reach other registers, so plain checks skip them
    logic pfx_q;
    always_ff @(posedge sys_clk_i) begin
        pfx_q <= (dmod == MOD_PFX);
    end
    a_reset_state: assert property (disable iff (1'b0) !nrst_i |=>
        prog_addr_o == PC_RST && acc_o == 16'h0000 && key_locked_o &&
        stack_top_index_o == STACK_TOP_RST && map_mode_o == MAP_HARVARD)
        else $error("reset state wrong");
    a_imm_acc: assert property (!pfx_q && !fmt && dst == 7'h09 |=>
        acc_o == {8'h00, $past(prog_rdata_i[7:0])}) else $error("imm move");
    a_reg_acc: assert property (!pfx_q && fmt && dst == 7'h09 &&
        !prog_rdata_i[3] |=> acc_o == $past(periph_rdata_i))
        else $error("register source move");
    a_dst_periph: assert property (!pfx_q && !dmod[3] |=>
        periph_wr_o && periph_sel_o == {1'b0, $past(dst)})
        else $error("destination decode");
    a_no_stray_wr: assert property (dmod[3] |=> !periph_wr_o)
        else $error("stray peripheral write");
    a_push_step: assert property (!pfx_q && dst == 7'h0D |=>
        stack_top_index_o == $past(stack_top_index_o) + 4'h1)
        else $error("push step");
    a_pop_step: assert property (fmt && prog_rdata_i[7:0] == 8'h0D &&
        dmod != MOD_STK |=>
        stack_top_index_o == $past(stack_top_index_o) - 4'h1)
        else $error("pop step");
    a_pc_one_step: assert property (dmod != MOD_PC |=>
        prog_addr_o == $past(prog_addr_o) + 16'h0001) else $error("pc step");
    a_bus_read: assert property (bus_rd_i |=> bus_rdata_o ==
        ($past(bus_addr_i[0]) ? $past(acc_o) : $past(prog_addr_o)))
        else $error("debug read");
    a_key_refuse: assert property (key_locked_o && data_req_o.rd |->
        data_req_o.addr[15:4] != 12'h001) else $error("key area read");
    c_push: cover property (!pfx_q && dst == 7'h0D);
    c_prefixed: cover property (pfx_q && !dmod[3]);
    c_bus_acc: cover property (bus_rd_i && bus_addr_i[0]);
endmodule
bind move_instruction_decoder move_instruction_decoder_chk chk (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .prog_rdata_i(prog_rdata_i),
    .periph_rdata_i(periph_rdata_i), .bus_addr_i(bus_addr_i),
    .bus_rd_i(bus_rd_i), .prog_addr_o(prog_addr_o),
    .data_req_o(data_req_o), .periph_sel_o(periph_sel_o),
    .periph_wr_o(periph_wr_o), .acc_o(acc_o),
    .stack_top_index_o(stack_top_index_o), .key_locked_o(key_locked_o),
    .map_mode_o(map_mode_o), .bus_rdata_o(bus_rdata_o));

// ===== tb/far_side_model.sv
`timescale 1ns/1ps
module far_side_model
    import move_decoder_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] op_i,
    input  wire mem_req_t    data_req_i,
    output logic      [15:0] prog_rdata_o,
    output logic      [15:0] data_rdata_o = 16'h0000,
    output logic      [15:0] periph_rdata_o
);
    assign prog_rdata_o   = op_i;
    // answer tied to the selector, so a wrong pick shows at once
    assign periph_rdata_o = {8'hA5, op_i[7:0]};
    // idle data line keeps toggling so a stale word never looks valid
    always_ff @(posedge sys_clk_i) begin
        if (data_req_i.rd) begin
            data_rdata_o <= ~data_req_i.addr;
        end else begin
            data_rdata_o <= ~data_rdata_o;
        end
    end
endmodule

// ===== tb/test_move_instruction_decoder.sv
`timescale 1ns/1ps
module test_move_instruction_decoder
    import move_decoder_pkg::*;
;
    localparam logic [15:0] NOP = 16'h8909;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic [15:0] op = NOP;
    logic [15:0] bus_addr_i = 16'h0000;
    logic [15:0] prog_rdata, data_rdata, periph_rdata, prog_addr_o;
    logic [15:0] periph_wdata_o, acc_o, bus_rdata_o;
    logic [7:0]  periph_sel_o;
    logic [3:0]  stack_top_index_o;
    logic [1:0]  map_mode_o;
    logic        periph_wr_o, key_locked_o;
    mem_req_t    data_req;
    int error_cnt = 0;
    int tests_run = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    move_instruction_decoder #(.NUM_DP(3)) dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .prog_rdata_i(prog_rdata),
        .data_rdata_i(data_rdata), .periph_rdata_i(periph_rdata),
        .bus_addr_i(bus_addr_i), .bus_wdata_i(16'h0000), .bus_wr_i(1'b0),
        .bus_rd_i(bus_rd_i), .prog_addr_o(prog_addr_o), .data_req_o(data_req),
        .periph_sel_o(periph_sel_o), .periph_wr_o(periph_wr_o),
        .periph_wdata_o(periph_wdata_o), .acc_o(acc_o),
        .stack_top_index_o(stack_top_index_o), .key_locked_o(key_locked_o),
        .map_mode_o(map_mode_o), .bus_rdata_o(bus_rdata_o));
    far_side_model far (
        .sys_clk_i(sys_clk_i), .op_i(op), .data_req_i(data_req),
        .prog_rdata_o(prog_rdata), .data_rdata_o(data_rdata),
        .periph_rdata_o(periph_rdata));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic exec(input logic [15:0] w);
        @(posedge sys_clk_i);
        op <= w;
        @(posedge sys_clk_i);
        op <= NOP;
        #1;
    endtask
    task automatic test_reset();
        check(prog_addr_o, PC_RST);
        check(acc_o, 16'h0000);
        check({12'h000, stack_top_index_o}, 16'h000F);
        check({14'h0000, map_mode_o}, 16'h0000);
        check({15'h0000, key_locked_o}, 16'h0001);
        $display("test reset done");
    endtask
    task automatic test_source();
        exec({1'b0, 7'h09, 8'h5A});
        check(acc_o, 16'h005A);
        exec({1'b1, 7'h09, 8'h32});
        check(acc_o, 16'hA532);
        $display("test source done");
    endtask
    task automatic test_dest();
        exec({1'b0, 7'h53, 8'h77});
        check({15'h0000, periph_wr_o}, 16'h0001);
        check({8'h00, periph_sel_o}, 16'h0053);
        check(periph_wdata_o, 16'h0077);
        @(posedge sys_clk_i);
        #1;
        check({15'h0000, periph_wr_o}, 16'h0000);
        $display("test destination done");
    endtask
    task automatic test_alu();
        logic [6:0]  dsts [4] = '{7'h28, 7'h38, 7'h58, 7'h78};
        logic [7:0]  imms [4] = '{8'h22, 8'h0F, 8'h40, 8'h03};
        logic [15:0] exps [4] = '{16'h0032, 16'h0002, 16'h0042, 16'h0041};
        exec({1'b0, 7'h09, 8'h10});
        for (int i = 0; i < 4; i++) begin
            exec({1'b0, dsts[i], imms[i]});
            check(acc_o, exps[i]);
        end
        $display("test alu done");
    endtask
    task automatic test_stack();
        exec({1'b0, 7'h0D, 8'h11});
        check({12'h000, stack_top_index_o}, 16'h0000);
        exec({1'b0, 7'h0D, 8'h22});
        check({12'h000, stack_top_index_o}, 16'h0001);
        exec({1'b1, 7'h09, 8'h0D});
        check(acc_o, 16'h0022);
        exec({1'b1, 7'h09, 8'h0D});
        check(acc_o, 16'h0011);
        check({12'h000, stack_top_index_o}, 16'h000F);
        $display("test stack done");
    endtask
    task automatic test_prefix();
        logic [15:0] p0;
        p0 = prog_addr_o;
        @(posedge sys_clk_i);
        op <= {1'b0, 7'h0B, 8'h01};
        @(posedge sys_clk_i);
        op <= {1'b0, 7'h03, 8'h44};
        #1;
        check({15'h0000, periph_wr_o}, 16'h0000);
        @(posedge sys_clk_i);
        op <= NOP;
        #1;
        check({15'h0000, periph_wr_o}, 16'h0001);
        check({12'h000, periph_sel_o[3:0]}, 16'h0003);
        check({15'h0000, periph_sel_o[7:4] != 4'h0}, 16'h0001);
        check(prog_addr_o, p0 + 16'h0003);
        $display("test prefix done");
    endtask
    task automatic bus_read(input logic [15:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        bus_rd_i <= 1'b0;
        #1;
        check(bus_rdata_o, exp);
    endtask
    task automatic test_bus();
        bus_read(16'h0001, 16'h0011);
        bus_read(16'h0003, 16'h0011);
        @(posedge sys_clk_i);
        #1;
        check(bus_rdata_o, 16'h0000);
        $display("test bus done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // under forty cycles are needed; this span of 4000 cycles is far beyond that
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge sys_clk_i);
        #1;
        test_reset();
        @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        test_source();
        test_dest();
        test_alu();
        test_stack();
        test_prefix();
        test_bus();
        print_verdict();
    end
endmodule
